// ---- bench/cfg_reset_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cfg_reset_defs.vh"
module cfg_reset_chk #(
   parameter POWERUP_DELAY_TIMER_CYCLES = `POWERUP_DELAY_TIMER_CYC
) (
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        overtemp_reset,
   input wire logic        watchdog_timeout,
   input wire logic        sleep_mode,
   input wire logic        program_verify_mode,
   input wire logic [13:0] ext_addr,
   input wire logic        ext_wr,
   input wire logic        self_wr,
   input wire logic        in_circuit_debugger_en,
   input wire logic        brownout_active,
   input wire logic        watchdog_enable,
   input wire logic        pin_pullup_en,
   input wire logic        ext_wr_grant,
   input wire logic        self_wr_grant,
   input wire logic        fetch_allow,
   input wire logic        sys_reset,
   input wire logic        reg_reset,
   input wire logic        master_clear_pin_oe,
   input wire logic        master_clear_pin_out
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ==========================================
   // sequences
   sequence run4;
      !sys_reset [*4];
   endsequence
   // the edge counts only if the part stays awake, else it is a wake-up
   sequence wdt_fire;
      $rose(watchdog_timeout) && !sleep_mode && watchdog_enable ##1 !sleep_mode [*2];
   endsequence
   sequence id_try;
      ext_wr && !program_verify_mode && ext_addr >= `ID_LO && ext_addr <= `ID_HI;
   endsequence
   // ==========================================
   // properties
   a_cfg_held: assert property (run4 |-> $stable({in_circuit_debugger_en, watchdog_enable, pin_pullup_en}))
      else $error("config output moved while running");
   a_pin_not_driven: assert property (!master_clear_pin_oe)
      else $error("reset pin driven");
   a_fetch_free: assert property (fetch_allow == !$past(sys_reset))
      else $error("fetch gated by more than reset");
   a_bor_sleep_off: assert property (sleep_mode |=> !brownout_active)
      else $error("brown-out active in sleep");
   a_self_grant_cause: assert property (self_wr_grant |-> $past(self_wr))
      else $error("self write grant without request");
   a_ext_grant_cause: assert property (ext_wr_grant |-> $past(ext_wr))
      else $error("external grant without request");
   a_id_refused: assert property (id_try |=> !ext_wr_grant)
      else $error("id location written outside verify mode");
   a_src_resets: assert property (overtemp_reset [*5] |-> sys_reset)
      else $error("reset not held for active source");
   a_wdt_resets: assert property (wdt_fire |-> ##[0:3] sys_reset)
      else $error("watchdog time-out gave no reset");
   a_pin_out_low: assert property (!master_clear_pin_out)
      else $error("reset pin output level set");
   a_reg_reset_held: assert property (reg_reset |-> sys_reset)
      else $error("register reset outside system reset");
endmodule // cfg_reset_chk
bind config_word_reset_control cfg_reset_chk #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER_CYCLES)) chk_i (.ref_clk, .rst,
   .overtemp_reset, .watchdog_timeout, .sleep_mode, .program_verify_mode, .ext_addr, .ext_wr, .self_wr,
   .in_circuit_debugger_en, .brownout_active, .watchdog_enable, .pin_pullup_en, .ext_wr_grant,
   .self_wr_grant, .fetch_allow, .sys_reset, .reg_reset, .master_clear_pin_oe, .master_clear_pin_out);
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // short delay so the run stays brief
   localparam int PW = 50;
   logic ref_clk = 1'h0, rst = 1'h1, por_event = 1'h0, overtemp_reset = 1'h0, brownout_low = 1'h0;
   logic watchdog_timeout = 1'h0, sleep_mode = 1'h0, master_clear_pin_in = 1'h1, program_verify_mode = 1'h0;
   logic ext_wr = 1'h0, self_wr = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
   logic [13:0] nv_config_word = 14'h2D78, ext_addr = 14'h0, ext_rd_data_raw = 14'h0, self_addr = 14'h0;
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0, reg_rdata;
   logic [13:0] ext_rd_data;
   logic in_circuit_debugger_en, brownout_active, watchdog_enable, pin_pullup_en;
   logic ext_wr_grant, self_wr_grant, fetch_allow, sys_reset, s;
   int error_cnt = 0, num_checks = 0, cycles = 0, n;
   config_word_reset_control #(.POWERUP_DELAY_TIMER_CYCLES(PW)) uut (.ref_clk, .rst, .por_event, .overtemp_reset,
      .brownout_low, .watchdog_timeout, .sleep_mode, .master_clear_pin_in, .program_verify_mode,
      .nv_config_word, .ext_addr, .ext_wr, .ext_rd_data_raw, .self_addr, .self_wr, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .in_circuit_debugger_en, .brownout_active, .watchdog_enable,
      .pin_pullup_en, .ext_wr_grant, .ext_rd_data, .self_wr_grant, .fetch_allow, .sys_reset,
      .reg_reset(), .master_clear_pin_oe(), .master_clear_pin_out());
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end
   // ==========================================
   // helpers
   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
   endtask
   task automatic chk(input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL %0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      cyc(1);
      reg_addr <= a;
      reg_rd <= 1'h1;
      cyc(1);
      reg_rd <= 1'h0;
      #1 chk(e, reg_rdata);
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      cyc(1);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'h1;
      cyc(1);
      reg_wr <= 1'h0;
   endtask
   task automatic wait_low(output int k);
      k = 0;
      while (sys_reset !== 1'h0 && k < 300) begin
         cyc(1);
         k++;
      end
      chk(1'h0, sys_reset);
   endtask
   task automatic watch(input int k, output logic v);
      v = 1'h0;
      repeat (k) begin
         cyc(1);
         v = v | sys_reset;
      end
   endtask
   task automatic por_load(input logic [13:0] w, output int k);
      cyc(1);
      nv_config_word <= w;
      por_event <= 1'h1;
      cyc(4);
      por_event <= 1'h0;
      wait_low(k);
   endtask
   task automatic pin_test(input int k, output logic v);
      cyc(1);
      master_clear_pin_in <= 1'h0;
      watch(k, v);
      master_clear_pin_in <= 1'h1;
      wait_low(n);
   endtask
   task automatic self_try(input logic [13:0] a, input logic g);
      cyc(1);
      self_addr <= a;
      self_wr <= 1'h1;
      cyc(1);
      self_wr <= 1'h0;
      #1 chk(g, self_wr_grant);
   endtask
   task automatic ext_try(input logic [13:0] a, input logic [13:0] raw, input logic g, input logic [13:0] e);
      cyc(1);
      ext_addr <= a;
      ext_rd_data_raw <= raw;
      ext_wr <= 1'h1;
      cyc(1);
      ext_wr <= 1'h0;
      #1 chk(g, ext_wr_grant);
      chk(e, ext_rd_data);
   endtask
   // ==========================================
   // scenarios
   task automatic t_cfg(input logic [13:0] w);
      por_load(w, n);
      wr(4'h0, 16'h0000);
      rd(4'h0, {2'h0, w | 14'h1287});
      chk(!w[13], in_circuit_debugger_en);
      chk(w[3], watchdog_enable);
      chk(w[8], brownout_active);
      chk(w[5], pin_pullup_en);
      pin_test(30, s);
      chk(w[5], s);
      watchdog_timeout <= 1'h1;
      watch(8, s);
      watchdog_timeout <= 1'h0;
      chk(w[3], s);
      wait_low(n);
   endtask
   task automatic t_prot();
      logic [13:0] lim [4];
      lim = '{14'h0FFF, 14'h07FF, 14'h03FF, 14'h0000};
      for (int i = 0; i < 4; i++) begin
         por_load(14'h2178 | 14'(i << 10), n);
         self_try(lim[i], i == 3);
         if (i != 0) self_try(lim[i] + 14'h1, 1'h1);
         chk(1'h1, fetch_allow);
      end
      ext_try(14'h0123, 14'h1ABC, 1'h1, 14'h1ABC);
      ext_try(14'h2001, 14'h0055, 1'h0, 14'h0000);
      cyc(1);
      program_verify_mode <= 1'h1;
      ext_try(14'h2003, 14'h0055, 1'h1, 14'h0055);
      cyc(1);
      program_verify_mode <= 1'h0;
      por_load(14'h2D38, n);
      ext_try(14'h0123, 14'h1ABC, 1'h0, 14'h0000);
      self_try(14'h0800, 1'h1);
      chk(1'h1, fetch_allow);
   endtask
   task automatic t_src();
      por_load(14'h2D78, n);
      chk(1'h1, n < 10);
      wr(4'h2, 16'h00A5);
      wr(4'h3, 16'h005A);
      wr(4'hF, 16'hFFFF);
      rd(4'hF, 16'h0000);
      wr(4'h1, 16'h000C);
      rd(4'h1, 16'h000F);
      cyc(1);
      watchdog_timeout <= 1'h1;
      watch(8, s);
      watchdog_timeout <= 1'h0;
      chk(1'h1, s);
      wait_low(n);
      rd(4'h1, 16'h000D);
      rd(4'h2, 16'h0000);
      rd(4'h3, 16'h005A);
      wr(4'h2, 16'h00A5);
      sleep_mode <= 1'h1;
      cyc(1);
      watchdog_timeout <= 1'h1;
      watch(8, s);
      watchdog_timeout <= 1'h0;
      chk(1'h0, s);
      rd(4'h1, 16'h000C);
      rd(4'h2, 16'h00A5);
      pin_test(30, s);
      rd(4'h1, 16'h000E);
      cyc(1);
      sleep_mode <= 1'h0;
      pin_test(10, s);
      chk(1'h0, s);
      pin_test(30, s);
      rd(4'h1, 16'h000E);
      rd(4'h2, 16'h0000);
      cyc(1);
      overtemp_reset <= 1'h1;
      watch(6, s);
      overtemp_reset <= 1'h0;
      chk(1'h1, s);
      wait_low(n);
   endtask
   task automatic t_bor();
      por_load(14'h2D68, n);
      chk(1'h1, n >= PW);
      wr(4'h1, 16'h000C);
      brownout_low <= 1'h1;
      watch(6, s);
      brownout_low <= 1'h0;
      chk(1'h1, s);
      wait_low(n);
      chk(1'h1, n < 10);
      rd(4'h1, 16'h000B);
      cyc(1);
      sleep_mode <= 1'h1;
      brownout_low <= 1'h1;
      watch(8, s);
      brownout_low <= 1'h0;
      // let the synchroniser drain before waking, else a late brown-out fires
      cyc(3);
      sleep_mode <= 1'h0;
      chk(1'h0, s);
   endtask
   task automatic print_verdict();
      if (error_cnt == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      cyc(4);
      rst <= 1'h0;
      wait_low(n);
      rd(4'h1, 16'h0003);
      t_cfg(14'h2D78);
      t_cfg(14'h0010);
      t_prot();
      t_src();
      t_bor();
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire

// ---- src/cfg_reset_defs.vh ----
// Behaviour
// - bit 13 one disables debug mode
// - write protect selector sets protected range
// - brown-out reset active only awake, enabled
// - code_protect_n zero protects program memory
// - protected: external writes blocked, reads zero
// - pin select: external reset plus pull-up
// - powerup_timer_en_n low enables power-up timer
// - watchdog_en one enables watchdog
// - unimplemented config bits read as one
// - brown-out never enables power-up timer
// - id locations only in program/verify mode
// - five reset sources give known state
// - power-up delay only after power-on
// - some registers kept through non-power-on resets
// - most registers reset on listed resets
// - watchdog wake-up is no register reset
// - power-on and brown-out flag updates
// - watchdog reset and wake-up flag updates
// - pin reset flag updates only asleep; awake leaves flags alone
// - pin reset glitches filtered out
// - power-up timer holds reset 64 ms
// - watchdog reset never drives pin
`ifndef CFG_RESET_DEFS_VH
`define CFG_RESET_DEFS_VH
// ==========================================
// config word fields
`define CFG_W              14
`define CFG_DBG_BIT        13
`define CFG_WRT_HI         11
`define CFG_WRT_LO         10
`define CFG_BOR_BIT        8
`define CFG_CP_BIT         6
`define CFG_PIN_BIT        5
`define CFG_POWERUP_DELAY_TIMER_BIT       4
`define CFG_WDT_BIT        3
`define CFG_UNIMPL_MASK    14'h1287
`define CFG_RESET          14'h3FFF
// ==========================================
// protection ranges
`define PM_AW              14
`define WRT_LIM_10         14'h03FF
`define WRT_LIM_01         14'h07FF
`define WRT_LIM_00         14'h0FFF
`define ID_LO              14'h2000
`define ID_HI              14'h2003
// ==========================================
// timing
`define CLK_MHZ            200
`define POWERUP_DELAY_TIMER_MS            64
`define POWERUP_DELAY_TIMER_CYC           (`POWERUP_DELAY_TIMER_MS * 1000 * `CLK_MHZ)
`define POWERUP_DELAY_TIMER_CW            24
`define FILT_NS            100
`define FILT_CYC           ((`FILT_NS * `CLK_MHZ) / 1000)
`define FILT_CW            5
// ==========================================
// register map
`define ADDR_W             4
`define A_CONFIG           4'h0
`define A_CAUSE            4'h1
`define A_SCRATCH          4'h2
`define A_KEEP             4'h3
`endif

// ---- src/config_word_reset_control.v ----
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_reset_defs.vh"
module config_word_reset_control #(
   parameter POWERUP_DELAY_TIMER_CYCLES = `POWERUP_DELAY_TIMER_CYC
) (
   input  wire                  ref_clk,
   input  wire                  rst,
   // reset sources, sleep and program/verify mode
   input  wire                  por_event,
   input  wire                  overtemp_reset,
   input  wire                  brownout_low,
   input  wire                  watchdog_timeout,
   input  wire                  sleep_mode,
   input  wire                  master_clear_pin_in,
   input  wire                  program_verify_mode,
   // nonvolatile word
   input  wire [`CFG_W-1:0]     nv_config_word,
   // program memory access requests
   input  wire [`PM_AW-1:0]     ext_addr,
   input  wire                  ext_wr,
   input  wire [`PM_AW-1:0]     ext_rd_data_raw,
   input  wire [`PM_AW-1:0]     self_addr,
   input  wire                  self_wr,
   // register port
   input  wire [`ADDR_W-1:0]    reg_addr,
   input  wire [15:0]           reg_wdata,
   input  wire                  reg_wr,
   input  wire                  reg_rd,
   output reg  [15:0]           reg_rdata,
   // decoded controls
   output reg                   in_circuit_debugger_en,
   output reg                   brownout_active,
   output reg                   watchdog_enable,
   output reg                   pin_pullup_en,
   output reg                   ext_wr_grant,
   output reg  [`PM_AW-1:0]     ext_rd_data,
   output reg                   self_wr_grant,
   output reg                   fetch_allow,
   output reg                   sys_reset,
   output reg                   reg_reset,
   output reg                   master_clear_pin_oe,
   output reg                   master_clear_pin_out
);
   // ==========================================
   // pin and event synchronisers
   reg [1:0] pin_s_reg;
   reg [1:0] por_s_reg;
   reg [1:0] ot_s_reg;
   reg [1:0] bo_s_reg;
   reg [1:0] wd_s_reg;
   wire      pin_filt;
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pin_s_reg <= 2'h3;
         por_s_reg <= 2'h0;
         ot_s_reg  <= 2'h0;
         bo_s_reg  <= 2'h0;
         wd_s_reg  <= 2'h0;
      end else begin
         pin_s_reg <= {pin_s_reg[0], master_clear_pin_in};
         por_s_reg <= {por_s_reg[0], por_event};
         ot_s_reg  <= {ot_s_reg[0], overtemp_reset};
         bo_s_reg  <= {bo_s_reg[0], brownout_low};
         wd_s_reg  <= {wd_s_reg[0], watchdog_timeout};
      end
   end

   glitch_filter u_filt (
      .ref_clk (ref_clk),
      .rst     (rst),
      .din     (pin_s_reg[1]),
      .dout    (pin_filt)
   );

   // ==========================================
   // configuration latch
   reg [`CFG_W-1:0] cfg_reg;
   always @(posedge ref_clk or posedge rst) begin
      if (rst)
         cfg_reg <= `CFG_RESET;
      else if (sys_reset)
         cfg_reg <= nv_config_word | `CFG_UNIMPL_MASK;
   end

   wire [1:0] wrt_sel  = cfg_reg[`CFG_WRT_HI:`CFG_WRT_LO];
   wire       cp_on    = ~cfg_reg[`CFG_CP_BIT];
   wire       pin_en   = cfg_reg[`CFG_PIN_BIT];
   wire       powerup_delay_timer_on  = ~cfg_reg[`CFG_POWERUP_DELAY_TIMER_BIT];
   wire       bor_act  = cfg_reg[`CFG_BOR_BIT] & ~sleep_mode;
   wire       por_src  = por_s_reg[1];
   wire       ot_src   = ot_s_reg[1];
   wire       bo_src   = bo_s_reg[1] & bor_act;
   wire       wd_evt   = wd_s_reg[1] & cfg_reg[`CFG_WDT_BIT];
   wire       pin_src  = pin_en & ~pin_filt;

   // ==========================================
   // reset combine and power-up timer
   reg [`POWERUP_DELAY_TIMER_CW-1:0] powerup_delay_timer_cnt_reg;
   reg                powerup_delay_timer_run_reg;
   reg                wd_prev_reg;
   reg                pin_prev_reg;
   wire               wd_rise  = wd_evt & ~wd_prev_reg;
   wire               pin_fall = pin_src & ~pin_prev_reg;
   wire               wd_rst   = wd_rise & ~sleep_mode;
   wire               wd_wake  = wd_rise & sleep_mode;
   wire               any_src  = por_src | ot_src | bo_src | pin_src | wd_rst;

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         powerup_delay_timer_cnt_reg <= {`POWERUP_DELAY_TIMER_CW{1'b0}};
         powerup_delay_timer_run_reg <= 1'b0;
         wd_prev_reg  <= 1'b0;
         pin_prev_reg <= 1'b0;
         sys_reset    <= 1'b1;
         reg_reset    <= 1'b1;
      end else begin
         wd_prev_reg  <= wd_evt;
         pin_prev_reg <= pin_src;
         // delay after power-on only; own bit
         if (por_src | bo_src) begin
            powerup_delay_timer_cnt_reg <= {`POWERUP_DELAY_TIMER_CW{1'b0}};
            powerup_delay_timer_run_reg <= por_src & powerup_delay_timer_on;
         end else if (powerup_delay_timer_run_reg) begin
            if (powerup_delay_timer_cnt_reg == POWERUP_DELAY_TIMER_CYCLES[`POWERUP_DELAY_TIMER_CW-1:0] - 1'b1)
               powerup_delay_timer_run_reg <= 1'b0;
            else
               powerup_delay_timer_cnt_reg <= powerup_delay_timer_cnt_reg + 1'b1;
         end
         sys_reset <= any_src | ((por_src | bo_src) ? por_src & powerup_delay_timer_on : powerup_delay_timer_run_reg);
         reg_reset <= any_src;
      end
   end

   // ==========================================
   // reset cause flags
   reg por_flag_reg;
   reg bor_flag_reg;
   reg to_n_reg;
   reg pd_n_reg;
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         por_flag_reg <= 1'b0;
         bor_flag_reg <= 1'b0;
         to_n_reg     <= 1'b1;
         pd_n_reg     <= 1'b1;
      end else begin
         if (por_src) begin
            por_flag_reg <= 1'b0;
            to_n_reg     <= 1'b1;
            pd_n_reg     <= 1'b1;
         end else if (bo_src) begin
            bor_flag_reg <= 1'b0;
            to_n_reg     <= 1'b1;
            pd_n_reg     <= 1'b1;
         end else if (wd_rst) begin
            to_n_reg <= 1'b0;
         end else if (wd_wake) begin
            to_n_reg <= 1'b0;
            pd_n_reg <= 1'b0;
         end else if (pin_fall & sleep_mode) begin
            to_n_reg <= 1'b1;
            pd_n_reg <= 1'b0;
         end else if (reg_wr && reg_addr == `A_CAUSE) begin
            // software sets flags to arm the next detection
            por_flag_reg <= reg_wdata[3];
            bor_flag_reg <= reg_wdata[2];
         end
         // pin reset awake leaves flags alone
      end
   end

   // ==========================================
   // software registers
   reg [15:0] scratch_reg;
   reg [15:0] keep_reg;
   always @(posedge ref_clk or posedge rst) begin
      if (rst)
         scratch_reg <= 16'h0000;
      else if (reg_reset)
         scratch_reg <= 16'h0000;
      else if (reg_wr && reg_addr == `A_SCRATCH)
         scratch_reg <= reg_wdata;
   end
   always @(posedge ref_clk) begin
      if (reg_wr && reg_addr == `A_KEEP && !reg_reset)
         keep_reg <= reg_wdata;
   end

   reg [15:0] rd_next;
   always @* begin
      case (reg_addr)
         `A_CONFIG:  rd_next = {2'h0, cfg_reg};
         `A_CAUSE:   rd_next = {12'h000, por_flag_reg, bor_flag_reg, to_n_reg, pd_n_reg};
         `A_SCRATCH: rd_next = scratch_reg;
         `A_KEEP:    rd_next = keep_reg;
         default:    rd_next = 16'h0000;
      endcase
   end

   // ==========================================
   // protection and outputs
   reg self_ok;
   always @* begin
      case (wrt_sel)
         2'b11:   self_ok = 1'b1;
         2'b10:   self_ok = self_addr > `WRT_LIM_10;
         2'b01:   self_ok = self_addr > `WRT_LIM_01;
         default: self_ok = self_addr > `WRT_LIM_00;
      endcase
   end
   wire id_hit = (ext_addr >= `ID_LO) && (ext_addr <= `ID_HI);
   wire id_ok  = ~id_hit | program_verify_mode;

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reg_rdata              <= 16'h0000;
         in_circuit_debugger_en <= 1'b0;
         brownout_active        <= 1'b0;
         watchdog_enable        <= 1'b0;
         pin_pullup_en          <= 1'b1;
         ext_wr_grant           <= 1'b0;
         ext_rd_data            <= {`PM_AW{1'b0}};
         self_wr_grant          <= 1'b0;
         fetch_allow            <= 1'b0;
         master_clear_pin_oe    <= 1'b0;
         master_clear_pin_out   <= 1'b0;
      end else begin
         reg_rdata              <= reg_rd ? rd_next : 16'h0000;
         in_circuit_debugger_en <= ~cfg_reg[`CFG_DBG_BIT];
         brownout_active        <= bor_act;
         watchdog_enable        <= cfg_reg[`CFG_WDT_BIT];
         pin_pullup_en          <= pin_en;
         ext_wr_grant           <= ext_wr & ~cp_on & id_ok;
         ext_rd_data            <= (cp_on | ~id_ok) ? {`PM_AW{1'b0}} : ext_rd_data_raw;
         self_wr_grant          <= self_wr & self_ok & ~sys_reset;
         fetch_allow            <= ~sys_reset;
         master_clear_pin_oe    <= 1'b0;
         master_clear_pin_out   <= 1'b0;
      end
   end
endmodule // config_word_reset_control
`default_nettype wire

// ---- src/glitch_filter.v ----
`timescale 1ns/1ps
`default_nettype none
`include "cfg_reset_defs.vh"
// ==========================================
// level filter: output follows input only after it has stood FILT_CYC cycles
module glitch_filter (
   input  wire ref_clk,
   input  wire rst,
   input  wire din,
   output reg  dout
);
   localparam FILT_LAST = `FILT_CYC - 1;
   reg [`FILT_CW-1:0] cnt_reg;
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= {`FILT_CW{1'b0}};
         dout    <= 1'b1;
      end else if (din == dout) begin
         cnt_reg <= {`FILT_CW{1'b0}};
      end else if (cnt_reg == FILT_LAST[`FILT_CW-1:0]) begin
         cnt_reg <= {`FILT_CW{1'b0}};
         dout    <= din;
      end else begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end
endmodule // glitch_filter
`default_nettype wire
